// [logic/gpb_pkg.sv]
// port pin block constants
// Notes on behaviour
// R1 - Port 0 has five bits: bits 0 and 4 are inputs only, bits 1 to 3 set their own direction.
// R2 - Ports 1, 2, 3, 5 and 6 have a direction bit per pin.
// R3 - A software pull-up acts only while its pin is an input.
// R4 - One direction bit covers all eight port 4 pins.
// R5 - A falling edge on any port 4 pin sets the port 4 fall flag.
// R6 - Software sets the subclock pin input select before reading the subclock crystal pin.
// R7 - A port 1 pin selected as analog input has its pull-up off.
// R8 - Port 6 bits 0 to 3 are open-drain with pull-ups fixed by a build option.
// R9 - External interrupt inputs 0 to 2 trigger on rising, falling or both edges.
// R10 - External interrupt input 3 triggers on falling edges only.
// R11 - Automatic serial transfers drive a strobe, and the peer raises busy while it cannot accept.
// R12 - External memory mode puts low address and data on port 4 and high address on port 5.
// R13 - An address latch strobe pulse lets outside logic latch the address before the data phase.
// R14 - External accesses use active-low read and write strobes that a wait input stretches.
// R15 - The timer output pin carries the 16-bit timer and the 14-bit PWM outputs.
// R16 - Reset leaves every pin an input with no alternate function.
// R17 - A read returns the pin level for input bits and the latch for output bits.
package gpb_pkg;
    localparam logic [7:0] ADDR_P0 = 8'h00;
    localparam logic [7:0] ADDR_P1 = 8'h04;
    localparam logic [7:0] ADDR_P2 = 8'h08;
    localparam logic [7:0] ADDR_P3 = 8'h0C;
    localparam logic [7:0] ADDR_P4 = 8'h10;
    localparam logic [7:0] ADDR_P5 = 8'h14;
    localparam logic [7:0] ADDR_P6 = 8'h18;
    localparam logic [7:0] ADDR_DIR0 = 8'h20;
    localparam logic [7:0] ADDR_DIR1 = 8'h24;
    localparam logic [7:0] ADDR_DIR2 = 8'h28;
    localparam logic [7:0] ADDR_DIR3 = 8'h2C;
    localparam logic [7:0] ADDR_DIR4 = 8'h30;
    localparam logic [7:0] ADDR_DIR5 = 8'h34;
    localparam logic [7:0] ADDR_DIR6 = 8'h38;
    localparam logic [7:0] ADDR_PU0 = 8'h40;
    localparam logic [7:0] ADDR_PU1 = 8'h44;
    localparam logic [7:0] ADDR_PU2 = 8'h48;
    localparam logic [7:0] ADDR_PU3 = 8'h4C;
    localparam logic [7:0] ADDR_PU4 = 8'h50;
    localparam logic [7:0] ADDR_PU5 = 8'h54;
    localparam logic [7:0] ADDR_PU6 = 8'h58;
    localparam logic [7:0] ADDR_ALT = 8'h60;
    localparam logic [7:0] ADDR_EDGE = 8'h64;
    localparam logic [7:0] ADDR_STAT = 8'h68;
    localparam logic [7:0] ADDR_MASK = 8'h6C;
    localparam logic [7:0] ADDR_ANSEL = 8'h70;
    localparam logic [7:0] ADDR_PROC = 8'h74;
    localparam logic [7:0] ADDR_XMEM = 8'h78;
    localparam logic [7:0] ADDR_XSTAT = 8'h7C;
    // port 0 bits that may drive
    localparam logic [4:0] P0_IO_MASK = 5'h0E;
    // alt register enables
    localparam int ALT_SER = 0;
    localparam int ALT_TMR = 1;
    localparam int ALT_PWM = 2;
    localparam int ALT_XMEM = 3;
    // proc bit: subclock pin input select
    localparam int PROC_SUBCLK = 6;
    // status bits: irq 0..3 and the port 4 fall flag
    localparam int STAT_W = 5;
    localparam int STAT_FALL = 4;
    // xmem command fields
    localparam int XM_ADDR_LSB = 8;
    localparam int XM_WRITE = 24;
    localparam int XM_GO = 31;
    localparam logic [1:0] XM_DATA_MIN = 2'h3;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    localparam logic [3:0] P6_OD_PULLUP = 4'hF;
    localparam logic [31:0] ZERO32 = 32'h0000_0000;
    localparam logic [7:0] ZERO8 = 8'h00;
    typedef enum logic [4:0] {
        GPB_XM_IDLE = 5'b00001,
        GPB_XM_ADDR = 5'b00010,
        GPB_XM_HOLD = 5'b00100,
        GPB_XM_DATA = 5'b01000,
        GPB_XM_DONE = 5'b10000
    } gpb_xm_e;
endpackage

// [logic/gpb_sync.sv]
// two-stage synchroniser for a bus of pin inputs
`timescale 1ns/1ns
`default_nettype none
module gpb_sync #(
    parameter int W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s1_d;
    logic [W-1:0] s2_d;
    // first stage feeds only the second stage
    always_comb
    begin
        s1_d = din;
        s2_d = s1_q;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_q <= '0;
            dout <= '0;
        end
        else
        begin
            s1_q <= s1_d;
            dout <= s2_d;
        end
    end
endmodule
`default_nettype wire

// [logic/gpb_edge.sv]
// edge detector with rise and fall select on a synchronised level
`timescale 1ns/1ns
`default_nettype none
module gpb_edge (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic lvl,
    input wire logic [1:0] sel,
    output logic hit
);
    logic prev_q;
    logic prev_d;
    always_comb
    begin
        prev_d = lvl;
        hit = (sel[0] & lvl & ~prev_q) | (sel[1] & ~lvl & prev_q);
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prev_q <= 1'b0;
        else
            prev_q <= prev_d;
    end
endmodule
`default_nettype wire

// [logic/gpb_top.sv]
// port pin block: seven ports, pin muxing, edge flags and external bus
`timescale 1ns/1ns
`default_nettype none
module gpb_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic [4:0] p0_in,
    output logic [4:0] p0_out,
    output logic [4:0] p0_oe_n,
    input wire logic [7:0] p1_in,
    output logic [7:0] p1_out,
    output logic [7:0] p1_oe_n,
    output logic [7:0] p1_pullup,
    input wire logic [7:0] p2_in,
    output logic [7:0] p2_out,
    output logic [7:0] p2_oe_n,
    output logic [7:0] p2_pullup,
    input wire logic [7:0] p3_in,
    output logic [7:0] p3_out,
    output logic [7:0] p3_oe_n,
    output logic [7:0] p3_pullup,
    input wire logic [7:0] p4_in,
    output logic [7:0] p4_out,
    output logic [7:0] p4_oe_n,
    output logic [7:0] p4_pullup,
    input wire logic [7:0] p5_in,
    output logic [7:0] p5_out,
    output logic [7:0] p5_oe_n,
    output logic [7:0] p5_pullup,
    input wire logic [7:0] p6_in,
    output logic [7:0] p6_out,
    output logic [7:0] p6_oe_n,
    output logic [7:0] p6_pullup,
    output logic [4:0] p0_pullup,
    output logic subclock_pin_input_select,
    input wire logic auto_xfer_active,
    input wire logic auto_xfer_strobe_src,
    output logic auto_xfer_busy,
    input wire logic timer16_out_src,
    input wire logic pwm14_out_src,
    output logic [3:0] ext_irq_level
);
    logic [4:0] s0;
    logic [7:0] s1, s2, s3, s4, s5, s6;
    logic [7:0] lat_q [7];
    logic [7:0] lat_d [7];
    logic [7:0] dir_q [7];
    logic [7:0] dir_d [7];
    logic [7:0] pu_q [7];
    logic [7:0] pu_d [7];
    logic [7:0] alt_q, alt_d, edge_q, edge_d, ansel_q, ansel_d, proc_q, proc_d;
    localparam int STAT_BITS = gpb_pkg::STAT_W;
    logic [1:0] dcnt_q, dcnt_d;
    logic [STAT_BITS-1:0] stat_q, stat_d, mask_q, mask_d, ev;
    logic [31:0] xcmd_q, xcmd_d;
    logic [7:0] xrd_q, xrd_d;
    logic xerr;
    gpb_pkg::gpb_xm_e xs_q, xs_d;
    logic [3:0] fall4;
    logic [7:0] fall_p4;
    logic wr_en, xm_en;

    gpb_sync #(.W(5)) u_s0 (.pclk(pclk), .presetn(presetn), .din(p0_in), .dout(s0));
    gpb_sync #(.W(8)) u_s1 (.pclk(pclk), .presetn(presetn), .din(p1_in), .dout(s1));
    gpb_sync #(.W(8)) u_s2 (.pclk(pclk), .presetn(presetn), .din(p2_in), .dout(s2));
    gpb_sync #(.W(8)) u_s3 (.pclk(pclk), .presetn(presetn), .din(p3_in), .dout(s3));
    gpb_sync #(.W(8)) u_s4 (.pclk(pclk), .presetn(presetn), .din(p4_in), .dout(s4));
    gpb_sync #(.W(8)) u_s5 (.pclk(pclk), .presetn(presetn), .din(p5_in), .dout(s5));
    gpb_sync #(.W(8)) u_s6 (.pclk(pclk), .presetn(presetn), .din(p6_in), .dout(s6));

    // irq 0..2 edge selectable, irq 3 falling only
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_irq
            gpb_edge u_e (
                .pclk(pclk),
                .presetn(presetn),
                .lvl(s0[gi]),
                .sel((gi == 3) ? gpb_pkg::EDGE_FALL : edge_q[2*gi +: 2]), // R9 R10
                .hit(fall4[gi])
            );
        end
        for (gi = 0; gi < 8; gi++)
        begin : g_p4
            gpb_edge u_f (
                .pclk(pclk),
                .presetn(presetn),
                .lvl(s4[gi]),
                .sel(gpb_pkg::EDGE_FALL),
                .hit(fall_p4[gi])
            );
        end
    endgenerate

    assign ext_irq_level = s0[3:0];
    assign wr_en = psel & penable & pwrite;
    assign pready = psel & penable;
    assign xm_en = alt_q[gpb_pkg::ALT_XMEM];

    // register writes; a status set wins over its clear
    always_comb
    begin
        lat_d = lat_q;
        dir_d = dir_q;
        pu_d = pu_q;
        alt_d = alt_q;
        edge_d = edge_q;
        ansel_d = ansel_q;
        proc_d = proc_q;
        mask_d = mask_q;
        ev = {|fall_p4, fall4}; // R5
        stat_d = stat_q;
        if (wr_en && paddr[7:5] == 3'h0)
            lat_d[paddr[4:2]] = pwdata[7:0];
        if (wr_en && paddr[7:5] == 3'h1)
            dir_d[paddr[4:2]] = pwdata[7:0];
        if (wr_en && paddr[7:5] == 3'h2)
            pu_d[paddr[4:2]] = pwdata[7:0];
        if (wr_en && paddr == gpb_pkg::ADDR_ALT)
            alt_d = pwdata[7:0];
        if (wr_en && paddr == gpb_pkg::ADDR_EDGE)
            edge_d = pwdata[7:0];
        if (wr_en && paddr == gpb_pkg::ADDR_MASK)
            mask_d = pwdata[STAT_BITS-1:0];
        if (wr_en && paddr == gpb_pkg::ADDR_ANSEL)
            ansel_d = pwdata[7:0];
        if (wr_en && paddr == gpb_pkg::ADDR_PROC)
            proc_d = pwdata[7:0];
        if (wr_en && paddr == gpb_pkg::ADDR_STAT)
            stat_d = stat_d & ~pwdata[STAT_BITS-1:0];
        stat_d = stat_d | ev;
    end

    // external access engine: address, latch strobe, data phase with wait
    always_comb
    begin
        xs_d = xs_q;
        xcmd_d = xcmd_q;
        xrd_d = xrd_q;
        xerr = 1'b0;
        dcnt_d = 2'h0;
        case (xs_q)
            gpb_pkg::GPB_XM_IDLE:
            begin
                if (wr_en && paddr == gpb_pkg::ADDR_XMEM && xm_en && pwdata[gpb_pkg::XM_GO])
                begin
                    xcmd_d = pwdata;
                    xs_d = gpb_pkg::GPB_XM_ADDR;
                end
            end
            gpb_pkg::GPB_XM_ADDR: xs_d = gpb_pkg::GPB_XM_HOLD; // R13
            gpb_pkg::GPB_XM_HOLD: xs_d = gpb_pkg::GPB_XM_DATA;
            gpb_pkg::GPB_XM_DATA:
            begin
                // synced wait lags; trust it after the minimum phase
                dcnt_d = dcnt_q + {1'b0, dcnt_q != gpb_pkg::XM_DATA_MIN};
                if (!s6[3] && dcnt_q == gpb_pkg::XM_DATA_MIN) // R14
                begin
                    xrd_d = s4;
                    xs_d = gpb_pkg::GPB_XM_DONE;
                end
            end
            gpb_pkg::GPB_XM_DONE: xs_d = gpb_pkg::GPB_XM_IDLE;
            default:
            begin
                xerr = 1'b1;
                xs_d = gpb_pkg::GPB_XM_IDLE;
            end
        endcase
        if (!xm_en && !xerr)
            xs_d = gpb_pkg::GPB_XM_IDLE;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 7; i++)
            begin
                lat_q[i] <= gpb_pkg::ZERO8;
                dir_q[i] <= gpb_pkg::ZERO8; // R16
                pu_q[i] <= gpb_pkg::ZERO8;
            end
            alt_q <= gpb_pkg::ZERO8; // R16
            edge_q <= gpb_pkg::ZERO8;
            ansel_q <= gpb_pkg::ZERO8;
            proc_q <= gpb_pkg::ZERO8;
            stat_q <= '0;
            mask_q <= '0;
            xs_q <= gpb_pkg::GPB_XM_IDLE;
            xcmd_q <= gpb_pkg::ZERO32;
            xrd_q <= gpb_pkg::ZERO8;
            dcnt_q <= 2'h0;
        end
        else
        begin
            lat_q <= lat_d;
            dir_q <= dir_d;
            pu_q <= pu_d;
            alt_q <= alt_d;
            edge_q <= edge_d;
            ansel_q <= ansel_d;
            proc_q <= proc_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            xs_q <= xs_d;
            xcmd_q <= xcmd_d;
            xrd_q <= xrd_d;
            dcnt_q <= dcnt_d;
        end
    end

    assign irq = |(stat_q & mask_q);
    assign subclock_pin_input_select = proc_q[gpb_pkg::PROC_SUBCLK]; // R6

    // pin drive: a set direction bit means output
    logic [7:0] oe4, oe5, oe6;
    logic xbusy, xwrite, xdata;
    always_comb
    begin
        xbusy = (xs_q != gpb_pkg::GPB_XM_IDLE);
        xwrite = xcmd_q[gpb_pkg::XM_WRITE];
        xdata = (xs_q == gpb_pkg::GPB_XM_DATA);
        p0_out = lat_q[0][4:0];
        p0_oe_n = ~(dir_q[0][4:0] & gpb_pkg::P0_IO_MASK); // R1
        p0_pullup = pu_q[0][4:0] & ~dir_q[0][4:0] & gpb_pkg::P0_IO_MASK; // R3
        p1_out = lat_q[1];
        p1_oe_n = ~dir_q[1]; // R2
        p1_pullup = pu_q[1] & ~dir_q[1] & ~ansel_q; // R7
        p2_out = lat_q[2];
        p2_oe_n = ~dir_q[2];
        p2_pullup = pu_q[2] & ~dir_q[2];
        // serial strobe on bit 3, busy in on bit 4
        if (alt_q[gpb_pkg::ALT_SER])
        begin
            p2_out[3] = auto_xfer_strobe_src; // R11
            p2_oe_n[3] = ~auto_xfer_active;
            p2_pullup[3] = 1'b0;
        end
        auto_xfer_busy = alt_q[gpb_pkg::ALT_SER] & s2[4]; // R11
        p3_out = lat_q[3];
        p3_oe_n = ~dir_q[3];
        if (alt_q[gpb_pkg::ALT_TMR] | alt_q[gpb_pkg::ALT_PWM])
        begin
            // pwm takes precedence when both are enabled
            p3_out[0] = alt_q[gpb_pkg::ALT_PWM] ? pwm14_out_src : timer16_out_src; // R15
            p3_oe_n[0] = 1'b0;
        end
        p3_pullup = pu_q[3] & ~dir_q[3] & p3_oe_n;
        // single direction bit for all of port 4
        oe4 = {8{dir_q[4][0]}}; // R4
        p4_out = lat_q[4];
        oe5 = dir_q[5];
        p5_out = lat_q[5];
        oe6 = dir_q[6];
        p6_out = lat_q[6];
        if (xm_en)
        begin
            oe4 = (xs_q == gpb_pkg::GPB_XM_ADDR || xs_q == gpb_pkg::GPB_XM_HOLD
                   || (xdata && xwrite)) ? 8'hFF : 8'h00; // R12
            p4_out = xdata ? xcmd_q[7:0] : xcmd_q[gpb_pkg::XM_ADDR_LSB +: 8];
            oe5 = 8'hFF;
            p5_out = xcmd_q[gpb_pkg::XM_ADDR_LSB+8 +: 8]; // R12
            oe6[7:4] = 4'hB;
            oe6[3] = 1'b0;
            p6_out[4] = ~(xdata & ~xwrite); // R14
            p6_out[5] = ~(xdata & xwrite); // R14
            p6_out[7] = (xs_q == gpb_pkg::GPB_XM_ADDR); // R13
        end
        p4_oe_n = ~oe4;
        p4_pullup = pu_q[4] & ~oe4; // R3
        p5_oe_n = ~oe5;
        p5_pullup = pu_q[5] & ~oe5;
        // open-drain nibble only pulls low
        p6_out[3:0] = 4'h0;
        p6_oe_n = ~oe6;
        p6_oe_n[3:0] = ~(oe6[3:0] & ~lat_q[6][3:0]); // R8
        p6_pullup = {pu_q[6][7:4] & ~oe6[7:4], gpb_pkg::P6_OD_PULLUP}; // R8
    end

    // read mux: pin level for inputs, latch for outputs
    function automatic logic [7:0] rdmix(input logic [7:0] pin, input logic [7:0] lat,
                                         input logic [7:0] dir);
        rdmix = (pin & ~dir) | (lat & dir); // R17
    endfunction

    always_comb
    begin
        prdata = gpb_pkg::ZERO32;
        pslverr = 1'b0;
        case (paddr)
            gpb_pkg::ADDR_P0: prdata[7:0] = rdmix({3'h0, s0}, lat_q[0],
                                                  dir_q[0] & {3'h0, gpb_pkg::P0_IO_MASK});
            gpb_pkg::ADDR_P1: prdata[7:0] = rdmix(s1, lat_q[1], dir_q[1]);
            gpb_pkg::ADDR_P2: prdata[7:0] = rdmix(s2, lat_q[2], dir_q[2]);
            gpb_pkg::ADDR_P3: prdata[7:0] = rdmix(s3, lat_q[3], dir_q[3]);
            gpb_pkg::ADDR_P4: prdata[7:0] = rdmix(s4, lat_q[4], {8{dir_q[4][0]}});
            gpb_pkg::ADDR_P5: prdata[7:0] = rdmix(s5, lat_q[5], dir_q[5]);
            gpb_pkg::ADDR_P6: prdata[7:0] = rdmix(s6, lat_q[6], dir_q[6]);
            gpb_pkg::ADDR_DIR0, gpb_pkg::ADDR_DIR1, gpb_pkg::ADDR_DIR2, gpb_pkg::ADDR_DIR3,
            gpb_pkg::ADDR_DIR4, gpb_pkg::ADDR_DIR5, gpb_pkg::ADDR_DIR6:
                prdata[7:0] = dir_q[paddr[4:2]];
            gpb_pkg::ADDR_PU0, gpb_pkg::ADDR_PU1, gpb_pkg::ADDR_PU2, gpb_pkg::ADDR_PU3,
            gpb_pkg::ADDR_PU4, gpb_pkg::ADDR_PU5, gpb_pkg::ADDR_PU6:
                prdata[7:0] = pu_q[paddr[4:2]];
            gpb_pkg::ADDR_ALT: prdata[7:0] = alt_q;
            gpb_pkg::ADDR_EDGE: prdata[7:0] = edge_q;
            gpb_pkg::ADDR_STAT: prdata[STAT_BITS-1:0] = stat_q;
            gpb_pkg::ADDR_MASK: prdata[STAT_BITS-1:0] = mask_q;
            gpb_pkg::ADDR_ANSEL: prdata[7:0] = ansel_q;
            gpb_pkg::ADDR_PROC: prdata[7:0] = proc_q;
            gpb_pkg::ADDR_XMEM: prdata = xcmd_q;
            gpb_pkg::ADDR_XSTAT: prdata[8:0] = {xbusy, xrd_q};
            default: pslverr = psel & penable;
        endcase
    end
endmodule
`default_nettype wire

// [dv/gpb_props.sv]
// checker for the port pin block
`timescale 1ns/1ns
`default_nettype none
module gpb_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [4:0] p0_in,
    input wire logic [4:0] p0_oe_n,
    input wire logic [4:0] p0_pullup,
    input wire logic [7:0] p1_oe_n,
    input wire logic [7:0] p1_pullup,
    input wire logic [7:0] p2_in,
    input wire logic [7:0] p2_oe_n,
    input wire logic [7:0] p2_pullup,
    input wire logic [7:0] p3_oe_n,
    input wire logic [7:0] p3_pullup,
    input wire logic [7:0] p4_oe_n,
    input wire logic [7:0] p4_pullup,
    input wire logic [7:0] p5_oe_n,
    input wire logic [7:0] p5_pullup,
    input wire logic [7:0] p6_in,
    input wire logic [7:0] p6_out,
    input wire logic [7:0] p6_oe_n,
    input wire logic [7:0] p6_pullup,
    input wire logic auto_xfer_busy,
    input wire logic [3:0] ext_irq_level
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // all pins inputs right after reset
    a_reset_all_input: assert property ($rose(presetn) |->
        (&{p0_oe_n, p1_oe_n, p2_oe_n, p3_oe_n, p4_oe_n, p5_oe_n, p6_oe_n}) && !p6_out[7])
        else $error("pin driven after reset");
    // no pull-up on a driving pin; port 6 low nibble is fixed
    a_pullup_input_only: assert property (((p1_pullup & ~p1_oe_n) | (p2_pullup & ~p2_oe_n)
        | (p3_pullup & ~p3_oe_n) | (p4_pullup & ~p4_oe_n) | (p5_pullup & ~p5_oe_n)
        | (p6_pullup & ~p6_oe_n & 8'hF0) | {3'h0, p0_pullup & ~p0_oe_n}) == 8'h00)
        else $error("pull-up while driving");
    a_p0_input_only: assert property (p0_oe_n[0] && p0_oe_n[4])
        else $error("port 0 input bit driven");
    a_p4_dir_whole: assert property (p4_oe_n == 8'h00 || p4_oe_n == 8'hFF)
        else $error("port 4 split");
    a_p6_open_drain: assert property (p6_pullup[3:0] == 4'hF
        && (p6_out[3:0] & ~p6_oe_n[3:0]) == 4'h0)
        else $error("open drain drove high");
    // two-edge sync history
    a_irq_pins_sync: assert property ($past(presetn) && $past(presetn, 2) |->
        ext_irq_level == $past(p0_in[3:0], 2))
        else $error("irq level not synced");
    a_busy_from_peer: assert property (auto_xfer_busy |-> $past(p2_in[4], 2))
        else $error("busy without peer");
    a_strobe_then_data: assert property ($rose(p6_out[7]) |=>
        !p6_out[7] ##1 (p6_out[5:4] != 2'h3))
        else $error("data before latch");
    a_addr_on_ports: assert property (p6_out[7] && !p6_oe_n[7] |->
        p4_oe_n == 8'h00 && p5_oe_n == 8'h00)
        else $error("address not driven");
    a_wait_holds: assert property (!p6_oe_n[4] && !p6_out[4] && $past(p6_in[3], 2)
        |=> !p6_out[4])
        else $error("read ended in wait");
    a_rdwr_exclusive: assert property (!p6_oe_n[5] |-> p6_out[5:4] != 2'h0)
        else $error("both strobes low");
endmodule
bind gpb_top gpb_props i_props (.*);
`default_nettype wire

// [dv/gpb_partner.sv]
// far-side model: external memory, address latch, busy peer
`timescale 1ns/1ns
`default_nettype none
module gpb_partner (
    input wire logic pclk,
    input wire logic [7:0] p4_out,
    input wire logic [7:0] p4_oe_n,
    input wire logic [7:0] p4_pullup,
    input wire logic [7:0] p5_out,
    input wire logic [7:0] p6_out,
    input wire logic [7:0] p6_oe_n,
    input wire logic [3:0] wait_len,
    input wire logic busy_req,
    output logic [7:0] p4_in,
    output logic wait_pin,
    output logic busy_pin
);
    logic [7:0] mem [256];
    logic [15:0] addr_q;
    logic [7:0] last_q;
    logic [3:0] wcnt;
    logic rd_n, wr_n;
    assign rd_n = p6_oe_n[4] | p6_out[4];
    assign wr_n = p6_oe_n[5] | p6_out[5];
    // bus level: design, else memory on a read, else pull-up or a toggling float
    assign p4_in = (p4_oe_n == 8'h00) ? p4_out : !rd_n ? mem[addr_q[7:0]]
        : (p4_pullup | ~last_q);
    assign busy_pin = busy_req;
    initial
    begin
        {wait_pin, wcnt, last_q, addr_q} = '0;
    end
    // latch address, store writes, stretch with wait
    always @(posedge pclk)
    begin
        last_q <= p4_in;
        if (p6_out[7] && !p6_oe_n[7]) addr_q <= {p5_out, p4_out};
        if (!wr_n) mem[addr_q[7:0]] <= p4_in;
        if (rd_n && wr_n) wcnt <= wait_len;
        else if (wcnt != 4'h0) wcnt <= wcnt - 4'h1;
        wait_pin <= !(rd_n && wr_n) && wcnt != 4'h0;
    end
endmodule
`default_nettype wire

// [dv/mcu_port_pin_block_test.sv]
// self-checking bench for the port pin block
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
    $display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end
module mcu_port_pin_block_test;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [32:0] rd;
    logic [4:0] p0_in, p0_out, p0_oe_n, p0_pullup;
    logic [7:0] p1_in, p1_out, p1_oe_n, p1_pullup, p2_in, p2_drv, p2_out, p2_oe_n;
    logic [7:0] p2_pullup, p3_in, p3_out, p3_oe_n, p3_pullup, p4_in, p4_out, p4_oe_n;
    logic [7:0] p4_pullup, p5_in, p5_out, p5_oe_n, p5_pullup, p6_in, p6_out, p6_oe_n, p6_pullup;
    logic subclock_pin_input_select, auto_xfer_active, auto_xfer_strobe_src, auto_xfer_busy;
    logic timer16_out_src, pwm14_out_src, wait_pin, busy_pin, busy_req;
    logic [3:0] ext_irq_level, wait_len;
    int bad_count, checks_done;
    assign p2_in = {p2_drv[7:5], busy_pin, p2_drv[3:0]};
    assign p6_in = {4'h0, wait_pin, 3'h0};
    gpb_top i_dut (.*);
    gpb_partner i_far (.*);
    initial
    begin
        pclk = 1'h0;
        forever #5 pclk = ~pclk;
    end
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // one transfer, held until pready at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1 && n < 20)
        begin
            @(posedge pclk);
            n++;
        end
        if (pready !== 1'h1)
        begin
            bad_count++;
            print_verdict;
        end
        rd = {pslverr, prdata};
        psel <= 1'h0;
        penable <= 1'h0;
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    task automatic t_reset;
        `CHK("oe_n", 8'hFF, p1_oe_n & p2_oe_n & p3_oe_n & p4_oe_n & p5_oe_n & p6_oe_n)
        `CHK("pullups", 48'h0F, {p1_pullup, p2_pullup, p3_pullup, p4_pullup, p5_pullup, p6_pullup})
        apb(1'h0, gpb_pkg::ADDR_DIR1, 32'h0);
        `CHK("dir1", 32'h0, rd)
        $display("test reset done");
    endtask
    task automatic t_dirs;
        p1_in <= 8'hF0;
        wr(gpb_pkg::ADDR_DIR1, 32'hA5);
        wr(gpb_pkg::ADDR_P1, 32'h3C);
        wr(gpb_pkg::ADDR_PU1, 32'hFF);
        wr(gpb_pkg::ADDR_ANSEL, 32'h02);
        wr(gpb_pkg::ADDR_DIR0, 32'h1F);
        wr(gpb_pkg::ADDR_DIR4, 32'h01);
        `CHK("p1 oe_n", 8'h5A, p1_oe_n)
        `CHK("p1 out", 8'h24, p1_out & 8'hA5)
        `CHK("p1 pullup", 8'h58, p1_pullup)
        `CHK("p0 oe_n", 5'h11, p0_oe_n)
        `CHK("p4 oe_n", 8'h00, p4_oe_n)
        apb(1'h0, gpb_pkg::ADDR_P1, 32'h0);
        `CHK("p1 read", 32'h74, rd)
        wr(gpb_pkg::ADDR_DIR6, 32'h0F);
        wr(gpb_pkg::ADDR_P6, 32'h05);
        `CHK("p6 od", 8'h50, {p6_oe_n[3:0], p6_out[3:0]})
        wr(gpb_pkg::ADDR_DIR6, 32'h0);
        apb(1'h0, 8'h80, 32'h0);
        `CHK("unmapped", 33'h100000000, rd)
        $display("test directions done");
    endtask
    task automatic t_irq;
        logic [31:0] m, e;
        wr(gpb_pkg::ADDR_PU4, 32'hFF);
        wr(gpb_pkg::ADDR_DIR4, 32'h0);
        wr(gpb_pkg::ADDR_MASK, 32'h1F);
        wr(gpb_pkg::ADDR_STAT, 32'h1F);
        // rise, fall, both on irq 0..2; irq 3 falls only
        for (m = 32'h1; m < 32'h4; m++)
        begin
            wr(gpb_pkg::ADDR_EDGE, m * 32'h15);
            p0_in <= 5'h0F;
            cyc(5);
            apb(1'h0, gpb_pkg::ADDR_STAT, 32'h0);
            e = m[0] ? 32'h7 : 32'h0;
            `CHK("stat rise", e, rd)
            `CHK("irq rise", |e, irq)
            wr(gpb_pkg::ADDR_STAT, 32'h1F);
            p0_in <= 5'h00;
            cyc(5);
            apb(1'h0, gpb_pkg::ADDR_STAT, 32'h0);
            e = (m[1] ? 32'h7 : 32'h0) | 32'h8;
            `CHK("stat fall", e, rd)
            wr(gpb_pkg::ADDR_STAT, 32'h1F);
        end
        // driving port 4 low over its pull-up gives a fall
        wr(gpb_pkg::ADDR_DIR4, 32'h01);
        cyc(4);
        apb(1'h0, gpb_pkg::ADDR_STAT, 32'h0);
        `CHK("fall flag", 32'h10, rd)
        wr(gpb_pkg::ADDR_MASK, 32'h0F);
        `CHK("irq masked", 1'h0, irq)
        wr(gpb_pkg::ADDR_MASK, 32'h1F);
        `CHK("irq unmasked", 1'h1, irq)
        wr(gpb_pkg::ADDR_STAT, 32'h10);
        `CHK("irq cleared", 1'h0, irq)
        wr(gpb_pkg::ADDR_DIR4, 32'h0);
        $display("test interrupts done");
    endtask
    task automatic xmem(input logic [31:0] cmd);
        int n = 0;
        wr(gpb_pkg::ADDR_XMEM, cmd);
        do
        begin
            apb(1'h0, gpb_pkg::ADDR_XSTAT, 32'h0);
            n++;
        end
        while (rd[8] !== 1'h0 && n < 40);
        `CHK("xmem idle", 1'h0, rd[8])
    endtask
    task automatic t_xmem;
        wr(gpb_pkg::ADDR_ALT, 32'h08);
        wait_len <= 4'h3;
        xmem(32'h8112345A);
        `CHK("mem data", 8'h5A, i_far.mem[8'h34])
        `CHK("latched addr", 16'h1234, i_far.addr_q)
        xmem(32'h80123400);
        `CHK("read data", 8'h5A, rd[7:0])
        $display("test external bus done");
    endtask
    task automatic t_alt;
        wr(gpb_pkg::ADDR_ALT, 32'h01);
        auto_xfer_active <= 1'h1;
        auto_xfer_strobe_src <= 1'h1;
        busy_req <= 1'h1;
        cyc(4);
        `CHK("busy strobe", 2'h3, {auto_xfer_busy, p2_out[3]})
        auto_xfer_strobe_src <= 1'h0;
        busy_req <= 1'h0;
        cyc(4);
        `CHK("idle strobe", 2'h0, {auto_xfer_busy, p2_out[3]})
        wr(gpb_pkg::ADDR_ALT, 32'h02);
        timer16_out_src <= 1'h1;
        cyc(1);
        `CHK("timer pin", 1'h1, p3_out[0])
        wr(gpb_pkg::ADDR_ALT, 32'h06);
        `CHK("pwm pin", 1'h0, p3_out[0])
        wr(gpb_pkg::ADDR_PROC, 32'h40);
        `CHK("subclock sel", 1'h1, subclock_pin_input_select)
        $display("test alternates done");
    endtask
    initial
    begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        print_verdict;
    end
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {p0_in, p1_in, p2_drv, p3_in, p5_in, wait_len, busy_req} = '0;
        {auto_xfer_active, auto_xfer_strobe_src, timer16_out_src, pwm14_out_src} = 4'h0;
        bad_count = 0;
        checks_done = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        #1;
        t_reset;
        t_dirs;
        t_irq;
        t_xmem;
        t_alt;
        print_verdict;
    end
endmodule
`default_nettype wire
